/* pkg/ccrb_bank_if.sv */
/*
  Carrier between the serial control engine and the register storage.
  Assumes both ends sit on the same clock.
*/
interface ccrb_bank_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic [7:0] rd_addr;
  logic [15:0] rd_data;
  logic [15:0] sys_word;
  logic [15:0] sub_word;
  logic [15:0] feat_word;
  logic [15:0] mvol_word;
  logic [15:0] bvol_word;
  logic [15:0] gain1_word;
  logic [15:0] gain2_word;

  modport engine (
    output wr_en, wr_addr, wr_data, rd_addr,
    input rd_data, sys_word, sub_word, feat_word, mvol_word, bvol_word, gain1_word, gain2_word
  );
  modport bank (
    input wr_en, wr_addr, wr_data, rd_addr,
    output rd_data, sys_word, sub_word, feat_word, mvol_word, bvol_word, gain1_word, gain2_word
  );
endinterface : ccrb_bank_if

/* pkg/ccrb_pkg.sv */
/*
  Constants, field layouts, defaults, state codes and lookups shared by the
  codec control register bank and its serial control engine.
  Assumes a single 250 MHz clock and an active-low asynchronous reset.
*/
package ccrb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ADDR_SYS = 8'h00;
  localparam logic [7:0] ADDR_SUB = 8'h01;
  localparam logic [7:0] ADDR_FEAT = 8'h10;
  localparam logic [7:0] ADDR_MVOL = 8'h11;
  localparam logic [7:0] ADDR_BVOL = 8'h12;
  localparam logic [7:0] ADDR_GAIN1 = 8'h20;
  localparam logic [7:0] ADDR_GAIN2 = 8'h21;
  localparam logic [7:0] ADDR_EVAL = 8'h30;
  localparam logic [7:0] PTR_STEP = 8'h01;

  localparam int NUM_WORDS = 7;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam logic [15:0] SYS_DEFAULT = 16'h1a02;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] SYS_MASK = 16'h7f7f;
  localparam logic [15:0] SUB_MASK = 16'h00ff;
  localparam logic [15:0] FULL_MASK = 16'hffff;
  localparam logic [15:0] GAIN_MASK = 16'h0fff;

  // system word fields
  localparam int SYS_RST = 15;
  localparam int SYS_QUICK = 14;
  localparam int SYS_MIXOFF = 13;
  localparam int SYS_OUTOFF = 12;
  localparam int SYS_CFG_LSB = 9;
  localparam int SYS_ADC_INV = 8;
  localparam int SYS_RATIO_LSB = 5;
  localparam int SYS_FMT_LSB = 2;
  localparam int SYS_DAC_PWR = 1;
  localparam int SYS_DAC_INV = 0;
  // sub system word fields
  localparam int SUB_OSR_LSB = 6;
  localparam int SUB_POS = 5;
  localparam int SUB_BLEND = 4;
  localparam int SUB_SIL_LSB = 2;
  localparam int SUB_MPO_LSB = 0;

  localparam logic [1:0] OSR_SINGLE = 2'h0;
  localparam logic [1:0] OSR_DOUBLE = 2'h1;
  localparam logic [1:0] OSR_QUAD = 2'h2;
  localparam logic [1:0] OSR_RSVD = 2'h3;
  localparam logic [2:0] CFG_OFF = 3'h0;

  // serial control link
  localparam logic [5:0] DEV_ADDR_HI = 6'h0d;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEV = 9'h002,
    ST_DEV_ACK = 9'h004,
    ST_REG = 9'h008,
    ST_REG_ACK = 9'h010,
    ST_WR = 9'h020,
    ST_WR_ACK = 9'h040,
    ST_RD = 9'h080,
    ST_RD_ACK = 9'h100
  } ccrb_state_t;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] slot_of(input logic [7:0] addr);
    case (addr)
      ADDR_SYS: slot_of = 3'h0;
      ADDR_SUB: slot_of = 3'h1;
      ADDR_FEAT: slot_of = 3'h2;
      ADDR_MVOL: slot_of = 3'h3;
      ADDR_BVOL: slot_of = 3'h4;
      ADDR_GAIN1: slot_of = 3'h5;
      ADDR_GAIN2: slot_of = 3'h6;
      default: slot_of = SLOT_NONE;
    endcase
  endfunction : slot_of

  function automatic logic [15:0] slot_mask(input logic [2:0] slot);
    case (slot)
      3'h0: slot_mask = SYS_MASK;
      3'h1: slot_mask = SUB_MASK;
      3'h5, 3'h6: slot_mask = GAIN_MASK;
      3'h7: slot_mask = ZERO_WORD;
      default: slot_mask = FULL_MASK;
    endcase
  endfunction : slot_mask

  function automatic logic [15:0] slot_default(input int slot);
    slot_default = (slot == 0) ? SYS_DEFAULT : ZERO_WORD;
  endfunction : slot_default

  function automatic logic [9:0] clock_ratio(input logic [1:0] code);
    case (code)
      2'h0: clock_ratio = 10'h100;
      2'h1: clock_ratio = 10'h180;
      2'h2: clock_ratio = 10'h200;
      default: clock_ratio = 10'h300;
    endcase
  endfunction : clock_ratio

  function automatic logic [14:0] silence_window(input logic [1:0] code);
    case (code)
      2'h0: silence_window = 15'h0c80;
      2'h1: silence_window = 15'h12c0;
      2'h2: silence_window = 15'h2580;
      default: silence_window = 15'h4b00;
    endcase
  endfunction : silence_window

endpackage : ccrb_pkg

/* rtl/ccrb_top.sv */
/*
  Codec control register bank: two-wire serial control slave, register
  storage and the decoded control outputs for the converter datapath.
  Assumes scl and sda come from off-chip and are open drain with pull-ups;
  the pad combines sda_out and sda_oe_n.
*/
module ccrb_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_sel_in,
  output logic quick_switch_sel,
  output logic adc_soft_change,
  output logic mixer_offset_filter_bypass,
  output logic output_offset_filter_on,
  output logic [2:0] conv_input_config,
  output logic conv_input_config_msb,
  output logic adc_invert,
  output logic adc_active,
  output logic [1:0] sys_clock_ratio,
  output logic [9:0] clock_ratio_mult,
  output logic [2:0] serial_format_sel,
  output logic dac_power_on,
  output logic dac_invert,
  output logic [1:0] oversample_rate_sel,
  output logic rate_reserved,
  output logic adc_supported,
  output logic dac_first_filter_bypass,
  output logic dac_features_usable,
  output logic master_ctrl_usable,
  output logic dac_blend_position,
  output logic dac_blend_enable,
  output logic dac_blend_active,
  output logic [1:0] silence_period_sel,
  output logic [14:0] silence_window,
  output logic [1:0] status_out_sel,
  output logic [15:0] dac_sound_features,
  output logic [15:0] dac_master_volume,
  output logic [15:0] dac_blend_volume,
  output logic [15:0] input_gain_channel_one,
  output logic [15:0] input_gain_channel_two
);

  ccrb_bank_if bank_bus ();

  ccrb_word_store u_store (
    .clk(clk),
    .nrst(nrst),
    .bus(bank_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic scl_prev_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;
  logic asel_meta_reg;
  logic asel_sync_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      asel_meta_reg <= 1'b0;
      asel_sync_reg <= 1'b0;
    end
    else
    begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      asel_meta_reg <= addr_sel_in;
      asel_sync_reg <= asel_meta_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise = scl_sync_reg && !scl_prev_reg;
  assign scl_fall = !scl_sync_reg && scl_prev_reg;
  assign start_seen = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
  assign stop_seen = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // serial engine state
  ccrb_pkg::ccrb_state_t state_reg;
  ccrb_pkg::ccrb_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] lo_reg;
  logic [7:0] lo_next;
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic rw_reg;
  logic rw_next;
  logic hi_reg;
  logic hi_next;
  logic nack_reg;
  logic nack_next;
  logic drive_reg;
  logic drive_next;
  logic wr_pulse;

  logic [7:0] ptr_inc;
  logic addr_match;
  logic byte_done;

  assign ptr_inc = 8'(ptr_reg + ccrb_pkg::PTR_STEP);
  assign addr_match = (shift_reg[7:1] == {ccrb_pkg::DEV_ADDR_HI, asel_sync_reg});
  assign byte_done = scl_fall && (cnt_reg == ccrb_pkg::BYTE_BITS);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ccrb_pkg::ST_IDLE;
      cnt_reg <= ccrb_pkg::CNT_ZERO;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      lo_reg <= 8'h00;
      hold_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      hi_reg <= 1'b1;
      nack_reg <= 1'b0;
      drive_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      lo_reg <= lo_next;
      hold_reg <= hold_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      hi_reg <= hi_next;
      nack_reg <= nack_next;
      drive_reg <= drive_next;
    end
  end

  // next word for a read follows the pointer on word boundaries
  assign bank_bus.rd_addr = (state_reg == ccrb_pkg::ST_RD_ACK) ? ptr_inc : ptr_reg;
  assign bank_bus.wr_en = wr_pulse;
  assign bank_bus.wr_addr = ptr_reg;
  assign bank_bus.wr_data = {hold_reg, shift_reg};

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    lo_next = lo_reg;
    hold_next = hold_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    hi_next = hi_reg;
    nack_next = nack_reg;
    drive_next = drive_reg;
    wr_pulse = 1'b0;
    if (stop_seen)
    begin
      state_next = ccrb_pkg::ST_IDLE;
      drive_next = 1'b0;
    end
    else if (start_seen)
    begin
      state_next = ccrb_pkg::ST_DEV;
      cnt_next = ccrb_pkg::CNT_ZERO;
      drive_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ccrb_pkg::ST_IDLE:
        begin
          drive_next = 1'b0;
        end
        ccrb_pkg::ST_DEV, ccrb_pkg::ST_REG, ccrb_pkg::ST_WR:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_sync_reg};
            cnt_next = 4'(cnt_reg + ccrb_pkg::CNT_STEP);
          end
          else if (byte_done)
          begin
            cnt_next = ccrb_pkg::CNT_ZERO;
            drive_next = 1'b1;
            if (state_reg == ccrb_pkg::ST_DEV)
            begin
              if (addr_match)
              begin
                state_next = ccrb_pkg::ST_DEV_ACK;
                rw_next = shift_reg[0];
              end
              else
              begin
                state_next = ccrb_pkg::ST_IDLE;
                drive_next = 1'b0;
              end
            end
            else if (state_reg == ccrb_pkg::ST_REG)
            begin
              state_next = ccrb_pkg::ST_REG_ACK;
              ptr_next = shift_reg;
              hi_next = 1'b1;
            end
            else
            begin
              state_next = ccrb_pkg::ST_WR_ACK;
              hi_next = !hi_reg;
              if (hi_reg)
                hold_next = shift_reg;
              else
              begin
                wr_pulse = 1'b1;
                ptr_next = ptr_inc;
              end
            end
          end
        end
        ccrb_pkg::ST_DEV_ACK:
        begin
          if (scl_fall)
          begin
            cnt_next = ccrb_pkg::CNT_ZERO;
            if (rw_reg)
            begin
              state_next = ccrb_pkg::ST_RD;
              tx_next = bank_bus.rd_data[15:8];
              lo_next = bank_bus.rd_data[7:0];
              hi_next = 1'b0;
              drive_next = !bank_bus.rd_data[15];
            end
            else
            begin
              state_next = ccrb_pkg::ST_REG;
              drive_next = 1'b0;
            end
          end
        end
        ccrb_pkg::ST_REG_ACK, ccrb_pkg::ST_WR_ACK:
        begin
          if (scl_fall)
          begin
            state_next = ccrb_pkg::ST_WR;
            drive_next = 1'b0;
          end
        end
        ccrb_pkg::ST_RD:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == ccrb_pkg::LAST_BIT)
            begin
              state_next = ccrb_pkg::ST_RD_ACK;
              drive_next = 1'b0;
            end
            else
            begin
              tx_next = {tx_reg[6:0], 1'b0};
              drive_next = !tx_reg[6];
              cnt_next = 4'(cnt_reg + ccrb_pkg::CNT_STEP);
            end
          end
        end
        ccrb_pkg::ST_RD_ACK:
        begin
          if (scl_rise)
            nack_next = sda_sync_reg;
          else if (scl_fall)
          begin
            cnt_next = ccrb_pkg::CNT_ZERO;
            if (nack_reg)
              state_next = ccrb_pkg::ST_IDLE;
            else
            begin
              state_next = ccrb_pkg::ST_RD;
              if (!hi_reg)
              begin
                tx_next = lo_reg;
                hi_next = 1'b1;
                drive_next = !lo_reg[7];
              end
              else
              begin
                ptr_next = ptr_inc;
                tx_next = bank_bus.rd_data[15:8];
                lo_next = bank_bus.rd_data[7:0];
                hi_next = 1'b0;
                drive_next = !bank_bus.rd_data[15];
              end
            end
          end
        end
        default:
        begin
          state_next = ccrb_pkg::ST_IDLE;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = !drive_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decoded control outputs
  logic [15:0] sys_w;
  logic [15:0] sub_w;
  logic [1:0] osr_w;
  logic [2:0] cfg_w;
  logic single_w;

  assign sys_w = bank_bus.sys_word;
  assign sub_w = bank_bus.sub_word;
  assign osr_w = sub_w[ccrb_pkg::SUB_OSR_LSB +: 2];
  assign cfg_w = sys_w[ccrb_pkg::SYS_CFG_LSB +: 3];
  assign single_w = (osr_w == ccrb_pkg::OSR_SINGLE);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      quick_switch_sel <= 1'b0;
      adc_soft_change <= 1'b0;
      mixer_offset_filter_bypass <= 1'b0;
      output_offset_filter_on <= 1'b0;
      conv_input_config <= 3'h0;
      conv_input_config_msb <= 1'b0;
      adc_invert <= 1'b0;
      adc_active <= 1'b0;
      sys_clock_ratio <= 2'h0;
      clock_ratio_mult <= 10'h000;
      serial_format_sel <= 3'h0;
      dac_power_on <= 1'b0;
      dac_invert <= 1'b0;
      oversample_rate_sel <= 2'h0;
      rate_reserved <= 1'b0;
      adc_supported <= 1'b0;
      dac_first_filter_bypass <= 1'b0;
      dac_features_usable <= 1'b0;
      master_ctrl_usable <= 1'b0;
      dac_blend_position <= 1'b0;
      dac_blend_enable <= 1'b0;
      dac_blend_active <= 1'b0;
      silence_period_sel <= 2'h0;
      silence_window <= 15'h0000;
      status_out_sel <= 2'h0;
      dac_sound_features <= 16'h0000;
      dac_master_volume <= 16'h0000;
      dac_blend_volume <= 16'h0000;
      input_gain_channel_one <= 16'h0000;
      input_gain_channel_two <= 16'h0000;
    end
    else
    begin
      quick_switch_sel <= sys_w[ccrb_pkg::SYS_QUICK];
      adc_soft_change <= !sys_w[ccrb_pkg::SYS_QUICK] && cfg_w[2];
      mixer_offset_filter_bypass <= sys_w[ccrb_pkg::SYS_MIXOFF];
      output_offset_filter_on <= sys_w[ccrb_pkg::SYS_OUTOFF];
      conv_input_config <= cfg_w;
      conv_input_config_msb <= cfg_w[2];
      adc_invert <= sys_w[ccrb_pkg::SYS_ADC_INV];
      adc_active <= single_w && (cfg_w != ccrb_pkg::CFG_OFF);
      sys_clock_ratio <= sys_w[ccrb_pkg::SYS_RATIO_LSB +: 2];
      clock_ratio_mult <= ccrb_pkg::clock_ratio(sys_w[ccrb_pkg::SYS_RATIO_LSB +: 2]);
      serial_format_sel <= sys_w[ccrb_pkg::SYS_FMT_LSB +: 3];
      dac_power_on <= sys_w[ccrb_pkg::SYS_DAC_PWR];
      dac_invert <= sys_w[ccrb_pkg::SYS_DAC_INV];
      oversample_rate_sel <= osr_w;
      rate_reserved <= (osr_w == ccrb_pkg::OSR_RSVD);
      adc_supported <= single_w;
      dac_first_filter_bypass <= (osr_w == ccrb_pkg::OSR_DOUBLE);
      dac_features_usable <= single_w;
      master_ctrl_usable <= single_w || (osr_w == ccrb_pkg::OSR_DOUBLE);
      dac_blend_position <= sub_w[ccrb_pkg::SUB_POS];
      dac_blend_enable <= sub_w[ccrb_pkg::SUB_BLEND];
      dac_blend_active <= sub_w[ccrb_pkg::SUB_BLEND] && single_w;
      silence_period_sel <= sub_w[ccrb_pkg::SUB_SIL_LSB +: 2];
      silence_window <= ccrb_pkg::silence_window(sub_w[ccrb_pkg::SUB_SIL_LSB +: 2]);
      status_out_sel <= sub_w[ccrb_pkg::SUB_MPO_LSB +: 2];
      dac_sound_features <= bank_bus.feat_word;
      dac_master_volume <= bank_bus.mvol_word;
      dac_blend_volume <= bank_bus.bvol_word;
      input_gain_channel_one <= bank_bus.gain1_word;
      input_gain_channel_two <= bank_bus.gain2_word;
    end
  end

endmodule : ccrb_top

/* rtl/ccrb_word_store.sv */
/*
  Flip-flop storage of the control words, with write masking, defaults
  and the soft default-load command.
  Assumes writes arrive as single-cycle strobes from the serial engine.
*/
module ccrb_word_store (
  input wire logic clk,
  input wire logic nrst,
  ccrb_bank_if.bank bus
);

  logic [15:0] word_reg [0:ccrb_pkg::NUM_WORDS-1];
  logic [2:0] wr_slot;
  logic [2:0] rd_slot;
  logic wr_hit;
  logic soft_load;

  assign wr_slot = ccrb_pkg::slot_of(bus.wr_addr);
  assign rd_slot = ccrb_pkg::slot_of(bus.rd_addr);
  assign wr_hit = bus.wr_en && (wr_slot != ccrb_pkg::SLOT_NONE);
  assign soft_load = wr_hit && (wr_slot == 3'h0) && bus.wr_data[ccrb_pkg::SYS_RST];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < ccrb_pkg::NUM_WORDS; i++)
        word_reg[i] <= ccrb_pkg::slot_default(i);
    end
    else if (soft_load)
    begin
      for (int i = 1; i < ccrb_pkg::NUM_WORDS; i++)
        word_reg[i] <= ccrb_pkg::slot_default(i);
    end
    else if (wr_hit)
      word_reg[wr_slot] <= bus.wr_data & ccrb_pkg::slot_mask(wr_slot);
  end

  // unmapped and evaluation addresses read zero
  assign bus.rd_data = (rd_slot == ccrb_pkg::SLOT_NONE) ? ccrb_pkg::ZERO_WORD : word_reg[rd_slot];
  assign bus.sys_word = word_reg[0];
  assign bus.sub_word = word_reg[1];
  assign bus.feat_word = word_reg[2];
  assign bus.mvol_word = word_reg[3];
  assign bus.bvol_word = word_reg[4];
  assign bus.gain1_word = word_reg[5];
  assign bus.gain2_word = word_reg[6];

endmodule : ccrb_word_store

/* verification/ccrb_assertions.sv */
/*
  Port checks of the codec control register bank.
  Assumes one clock and an active-low async reset.
*/
module ccrb_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic quick_switch_sel,
  input wire logic adc_soft_change,
  input wire logic output_offset_filter_on,
  input wire logic [2:0] conv_input_config,
  input wire logic conv_input_config_msb,
  input wire logic [1:0] sys_clock_ratio,
  input wire logic [9:0] clock_ratio_mult,
  input wire logic dac_power_on,
  input wire logic [1:0] oversample_rate_sel,
  input wire logic adc_supported,
  input wire logic rate_reserved,
  input wire logic dac_blend_enable,
  input wire logic dac_blend_active,
  input wire logic [1:0] silence_period_sel,
  input wire logic [14:0] silence_window
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] MULT [4] = '{10'h100, 10'h180, 10'h200, 10'h300};
  localparam logic [14:0] SIL [4] = '{15'h0c80, 15'h12c0, 15'h2580, 15'h4b00};
  logic up_reg;
  // outputs still show reset zeros at the first edge after release
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      up_reg <= 1'b0;
    else
      up_reg <= 1'b1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  a_reset_defaults: assert property ($rose(up_reg) |->
    output_offset_filter_on && dac_power_on && conv_input_config == 3'h5)
    else $error("defaults missing");
  a_soft_change: assert property (up_reg |->
    adc_soft_change == (!quick_switch_sel && conv_input_config_msb))
    else $error("soft change wrong");
  a_config_msb: assert property (up_reg |-> conv_input_config_msb == conv_input_config[2])
    else $error("config msb wrong");
  a_ratio_mult: assert property (up_reg |-> clock_ratio_mult == MULT[sys_clock_ratio])
    else $error("clock ratio wrong");
  a_silence_len: assert property (up_reg |-> silence_window == SIL[silence_period_sel])
    else $error("silence window wrong");
  a_rate_adc: assert property (up_reg |-> adc_supported == (oversample_rate_sel == 2'h0))
    else $error("adc support wrong");
  a_rate_reserved: assert property (up_reg |-> rate_reserved == (oversample_rate_sel == 2'h3))
    else $error("reserved rate wrong");
  a_blend_gate: assert property (up_reg |->
    dac_blend_active == (dac_blend_enable && oversample_rate_sel == 2'h0))
    else $error("blend gate wrong");
endmodule : ccrb_assertions
bind ccrb_top ccrb_assertions ccrb_assertions_inst (.*);

/* verification/ccrb_host_model.sv */
/*
  Host controller: two-wire serial master.
  Assumes an open-drain data wire with a pull-up.
*/
module ccrb_host_model (
  input wire logic clk,
  input wire logic sda_oe_n,
  input wire logic addr_sel,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_m = 1'b1;
  assign sda = sda_m & sda_oe_n;
  initial scl = 1'b1;
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // scl phases of 8 cycles stay clear of the 4-cycle minimum
  task automatic bit_io(input logic b, output logic r);
    tick(4);
    sda_m <= b;
    tick(4);
    scl <= 1'b1;
    tick(8);
    r = sda;
    scl <= 1'b0;
  endtask : bit_io
  task automatic cond(input logic first, input logic last);
    tick(4);
    sda_m <= first;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_m <= last;
    tick(8);
  endtask : cond
  task automatic xfer(input logic [7:0] b, input logic m, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(m, a);
  endtask : xfer
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [31:0] d, input logic two,
    output logic ok);
    logic [7:0] r;
    logic [5:0] a;
    a = '0;
    cond(1'b1, 1'b0);
    scl <= 1'b0;
    xfer({dev, 1'b0}, 1'b1, r, a[0]);
    xfer(ra, 1'b1, r, a[1]);
    for (int k = 0; k < (two ? 4 : 2); k++) xfer(d[31-8*k -: 8], 1'b1, r, a[k+2]);
    cond(1'b0, 1'b1);
    ok = !(|a);
  endtask : wr
  task automatic rd(input logic [7:0] ra, input logic two, output logic [31:0] d);
    logic [7:0] r;
    logic a;
    d = '0;
    cond(1'b1, 1'b0);
    scl <= 1'b0;
    xfer({ccrb_pkg::DEV_ADDR_HI, addr_sel, 1'b0}, 1'b1, r, a);
    xfer(ra, 1'b1, r, a);
    cond(1'b1, 1'b0);
    scl <= 1'b0;
    xfer({ccrb_pkg::DEV_ADDR_HI, addr_sel, 1'b1}, 1'b1, r, a);
    for (int k = 0; k < (two ? 4 : 2); k++) xfer(8'hff, k == (two ? 3 : 1), d[31-8*k -: 8], a);
    cond(1'b0, 1'b1);
  endtask : rd
endmodule : ccrb_host_model

/* verification/tb_codec_control_register_bank.sv */
/*
  Self-checking bench of the codec control register bank.
  Assumes the host model drives the serial pins.
*/
module tb_codec_control_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic addr_sel_in = 1'b0;
  logic scl_in, sda_in, sda_out, sda_oe_n, quick_switch_sel, adc_soft_change, mixer_offset_filter_bypass;
  logic output_offset_filter_on, conv_input_config_msb, adc_invert, adc_active, dac_power_on, dac_invert;
  logic rate_reserved, adc_supported, dac_first_filter_bypass, dac_features_usable, master_ctrl_usable;
  logic dac_blend_position, dac_blend_enable, dac_blend_active;
  logic [2:0] conv_input_config, serial_format_sel;
  logic [1:0] sys_clock_ratio, oversample_rate_sel, silence_period_sel, status_out_sel;
  logic [9:0] clock_ratio_mult;
  logic [14:0] silence_window;
  logic [15:0] dac_sound_features, dac_master_volume, dac_blend_volume, input_gain_channel_one, input_gain_channel_two;
  logic [15:0] shadow [256];
  localparam logic [7:0] ADDRS [10] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h30, 8'h05, 8'hff};
  localparam logic [9:0] MULT [4] = '{10'h100, 10'h180, 10'h200, 10'h300};
  localparam logic [14:0] SIL [4] = '{15'h0c80, 15'h12c0, 15'h2580, 15'h4b00};
  int fail_count = 0;
  int samples_checked = 0;
  logic ok;
  logic [31:0] got;
  logic [15:0] d;
  logic [7:0] a;
  ccrb_top ccrb_top_inst (.*);
  ccrb_host_model ccrb_host_model_inst (.clk, .sda_oe_n, .addr_sel(addr_sel_in), .scl(scl_in), .sda(sda_in));
  initial
  begin
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [15:0] mask(input logic [7:0] ad);
    case (ad)
      8'h00: return 16'h7f7f;
      8'h01: return 16'h00ff;
      8'h10, 8'h11, 8'h12: return 16'hffff;
      8'h20, 8'h21: return 16'h0fff;
      default: return 16'h0000;
    endcase
  endfunction : mask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic put(input logic [7:0] ad, input logic [15:0] v);
    if (ad == 8'h00 && v[15])
      for (int i = 1; i < 256; i++) shadow[i] = 16'h0000;
    else
      shadow[ad] = v & mask(ad);
  endtask : put
  task automatic outs();
    chk({1'b0, quick_switch_sel, mixer_offset_filter_bypass, output_offset_filter_on, conv_input_config,
      adc_invert, 1'b0, sys_clock_ratio, serial_format_sel, dac_power_on, dac_invert},
      shadow[0]);
    chk({12'h000, adc_active, dac_first_filter_bypass, dac_features_usable, master_ctrl_usable},
      {12'h000, shadow[1][7:6] == 2'h0 && shadow[0][11:9] != 3'h0, shadow[1][7:6] == 2'h1,
      shadow[1][7:6] == 2'h0, !shadow[1][7]});
    chk(dac_sound_features, shadow[8'h10]);
    chk(dac_blend_volume, shadow[8'h12]);
    chk(input_gain_channel_one, shadow[8'h20]);
    chk({8'h00, oversample_rate_sel, dac_blend_position, dac_blend_enable, silence_period_sel, status_out_sel},
      shadow[1]);
    chk({6'h00, clock_ratio_mult}, {6'h00, MULT[shadow[0][6:5]]});
    chk({1'b0, silence_window}, {1'b0, SIL[shadow[1][3:2]]});
    chk(dac_master_volume, shadow[8'h11]);
    chk(input_gain_channel_two, shadow[8'h21]);
  endtask : outs
  task automatic readall();
    foreach (ADDRS[i])
    begin
      ccrb_host_model_inst.rd(ADDRS[i], 1'b0, got);
      chk(got[31:16], shadow[ADDRS[i]]);
    end
    outs();
  endtask : readall
  task automatic do_reset();
    for (int i = 0; i < 256; i++) shadow[i] = 16'h0000;
    shadow[0] = 16'h1a02;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (90000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial
  begin
    void'($urandom(87421));
    addr_sel_in <= 1'($urandom());
    do_reset();
    readall();
    repeat (16)
    begin
      a = ADDRS[$urandom_range(9)];
      d = 16'($urandom());
      ccrb_host_model_inst.wr({ccrb_pkg::DEV_ADDR_HI, addr_sel_in}, a, {d, 16'h0000}, 1'b0, ok);
      chk({15'h0000, ok}, 16'h0001);
      put(a, d);
      ccrb_host_model_inst.rd(a, 1'b0, got);
      chk(got[31:16], shadow[a]);
      outs();
    end
    // two words in one transfer land at consecutive addresses
    ccrb_host_model_inst.wr({ccrb_pkg::DEV_ADDR_HI, addr_sel_in}, 8'h20, 32'hbeef_5a5a, 1'b1, ok);
    put(8'h20, 16'hbeef);
    put(8'h21, 16'h5a5a);
    ccrb_host_model_inst.rd(8'h20, 1'b1, got);
    chk(got[31:16], shadow[8'h20]);
    chk(got[15:0], shadow[8'h21]);
    ccrb_host_model_inst.wr({ccrb_pkg::DEV_ADDR_HI, ~addr_sel_in}, 8'h11, 32'h1234_0000, 1'b0, ok);
    chk({15'h0000, ok}, 16'h0000);
    ccrb_host_model_inst.wr({ccrb_pkg::DEV_ADDR_HI, addr_sel_in}, 8'h00, 32'hffff_0000, 1'b0, ok);
    put(8'h00, 16'hffff);
    readall();
    do_reset();
    readall();
    finish_test();
  end
endmodule : tb_codec_control_register_bank
